/* File: inc/fspr_pkg.sv */
package fspr_pkg;

  // decoded command codes
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_RDSR1     = 8'h05;
  localparam logic [7:0] OP_RDSR2     = 8'h35;
  localparam logic [7:0] OP_RDSR3     = 8'h15;
  localparam logic [7:0] OP_WRSR1     = 8'h01;
  localparam logic [7:0] OP_WRSR2     = 8'h31;
  localparam logic [7:0] OP_WRSR3     = 8'h11;
  localparam logic [7:0] OP_PROG      = 8'h02;
  localparam logic [7:0] OP_QPROG     = 8'h32;
  localparam logic [7:0] OP_SECT_ER   = 8'h20;
  localparam logic [7:0] OP_BLK32_ER  = 8'h52;
  localparam logic [7:0] OP_BLK64_ER  = 8'hD8;
  localparam logic [7:0] OP_CHIP_ER_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ER_B = 8'hC7;
  localparam logic [7:0] OP_SUSPEND   = 8'h75;
  localparam logic [7:0] OP_RESUME    = 8'h7A;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;

  // status protect modes {status_protect_hi, status_protect_lo}
  localparam logic [1:0] SRP_SOFTWARE = 2'h0;
  localparam logic [1:0] SRP_HARDWARE = 2'h1;
  localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
  localparam logic [1:0] SRP_ONE_TIME = 2'h3;

  // field positions inside each status byte
  localparam int B1_SRP_LO = 7;
  localparam int B1_BP_LSB = 2;
  localparam int B1_WEL    = 1;
  localparam int B1_BUSY   = 0;
  localparam int B2_ESUS   = 7;
  localparam int B2_CMP    = 6;
  localparam int B2_LB_LSB = 3;
  localparam int B2_PSUS   = 2;
  localparam int B2_QE     = 1;
  localparam int B2_SRP_HI = 0;
  localparam int B3_HOLD   = 7;
  localparam int B3_DRV_LSB = 5;
  localparam int B3_DC     = 0;

  // values after reset
  localparam logic [4:0] RST_BP       = 5'h00;
  localparam logic [1:0] RST_SRP      = 2'h0;
  localparam logic       RST_QE       = 1'b0;
  localparam logic       RST_CMP      = 1'b0;
  localparam logic [2:0] RST_LB       = 3'h0;
  localparam logic       RST_DC       = 1'b0;
  localparam logic [1:0] RST_DRV      = 2'h1;
  localparam logic       RST_HOLD_SEL = 1'b1;

  // drive strength codes
  localparam logic [1:0] DRV_FULL    = 2'h0;
  localparam logic [1:0] DRV_3QUART  = 2'h1;
  localparam logic [1:0] DRV_HALF    = 2'h2;
  localparam logic [1:0] DRV_QUARTER = 2'h3;

  // dummy cycle counts
  localparam logic [3:0] DUMMY_DUAL_DC0 = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_DC1 = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_DC0 = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_DC1 = 4'hA;

  // status write busy time in system cycles
  localparam logic [7:0] SR_WRITE_CYC = 8'h10;

  // link reset stretch in system cycles, spans several link periods
  localparam logic [4:0] RST_STRETCH_CYC = 5'h10;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] data;
  } fspr_cmd_t;

  typedef struct packed {
    logic [7:0] rd_byte;
    logic       dummy_config_bit;
  } fspr_resp_t;

endpackage

/* File: hdl/fspr_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// RL1 - write enable latch clear rejects status writes, programs and erases
// RL2 - five block protect bits select region shielded from program and erase
// RL3 - block protect bits change only outside hardware protected mode
// RL4 - chip erase only with low protect bits all zero/cmp0 or all one/cmp1
// RL5 - protect mode 00 accepts status writes whenever latch is set
// RL6 - protect mode 01 with write-protect pin low refuses status writes
// RL7 - protect mode 01 with write-protect pin high accepts writes with latch
// RL8 - lock-down mode 10 refuses writes until power cycle clears it
// RL9 - protect mode 11 makes status register permanently unwritable; rst_i clears srp_reg here, as in mode 10
// RL10 - quad enable clear keeps pin functions, set turns pins into data
// RL11 - three security lock bits start clear and set individually by write
// RL12 - a set security lock bit never clears again; rst_i clears lb_reg here
// RL13 - complement bit combines with block protect bits for region choice
// RL14 - suspend sets erase or program suspended flag by operation kind
// RL15 - resume, software reset pair and power cycle clear suspend flags
// RL16 - dual io read uses 4 dummy cycles, or 8 with dummy bit set
// RL17 - quad io read uses 6 dummy cycles, or 10 with dummy bit set
// RL18 - host writes zero to reserved status bits
// RL19 - drive field 00 full, 01 three quarters default, 10 half, 11 quarter
// RL20 - hold/reset select clear makes shared pin a hardware reset
// RL21 - busy flag high during program, erase or status write
// RL22 - quad enable set disables hold and reset on the shared pin
// RL23 - hold/reset select set with quad off makes shared pin a hold
module fspr_regs (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 lnk_clk_i,
  input  wire logic                 cmd_valid_i,
  input  wire fspr_pkg::fspr_cmd_t  cmd_i,
  output logic                      cmd_ready_o,
  output logic                      resp_valid_o,
  output logic [7:0]                rd_byte_o,
  output logic [3:0]                dummy_dual_o,
  output logic [3:0]                dummy_quad_o,
  input  wire logic                 wp_n_i,
  input  wire logic                 hold_rst_n_i,
  input  wire logic                 array_busy_i,
  input  wire logic                 array_is_erase_i,
  input  wire logic                 region_hit_i,
  output logic [4:0]                block_protect_o,
  output logic                      protect_complement_o,
  output logic                      prog_start_o,
  output logic                      erase_start_o,
  output logic                      chip_erase_start_o,
  output logic                      cmd_reject_o,
  output logic                      erase_suspend_o,
  output logic                      program_suspend_o,
  output logic                      resume_o,
  output logic [2:0]                security_lock_o,
  output logic [1:0]                drive_strength_o,
  output logic                      quad_enable_o,
  output logic                      hold_o,
  output logic                      pin_reset_o,
  output logic                      busy_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: command capture and answer

  logic                lnk_rst_s1_reg;
  logic                lnk_rst_reg;
  logic                req_tgl_reg;
  logic                pending_reg;
  fspr_pkg::fspr_cmd_t cmd_hold_reg;
  logic                ack_s1_reg;
  logic                ack_s2_reg;
  logic                ack_seen_reg;
  logic                lnk_dc_reg;
  logic                ack_evt;

  logic [4:0]          rst_hold_cnt_reg;
  logic                rst_hold_reg;

  // reset stretched on the system side so the slower link clock sees it
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rst_hold_cnt_reg <= fspr_pkg::RST_STRETCH_CYC;
    else if (rst_hold_cnt_reg != 5'h00)
      rst_hold_cnt_reg <= rst_hold_cnt_reg - 5'h01;
  end

  always_ff @(posedge clk_sys_i)
  begin
    rst_hold_reg <= rst_i || (rst_hold_cnt_reg != 5'h00);
  end

  always_ff @(posedge lnk_clk_i)
  begin
    lnk_rst_s1_reg <= rst_hold_reg;
    lnk_rst_reg    <= lnk_rst_s1_reg;
  end

  assign cmd_ready_o = !pending_reg && !lnk_rst_reg;
  assign ack_evt     = ack_s2_reg ^ ack_seen_reg;

  always_ff @(posedge lnk_clk_i)
  begin
    if (lnk_rst_reg)
    begin
      req_tgl_reg  <= 1'b0;
      pending_reg  <= 1'b0;
      cmd_hold_reg <= '0;
    end
    else if (cmd_valid_i && !pending_reg)
    begin
      req_tgl_reg  <= !req_tgl_reg;
      pending_reg  <= 1'b1;
      cmd_hold_reg <= cmd_i;
    end
    else if (ack_evt)
    begin
      pending_reg <= 1'b0;
    end
  end

  logic                ack_tgl_reg;
  fspr_pkg::fspr_resp_t resp_reg;

  always_ff @(posedge lnk_clk_i)
  begin
    if (lnk_rst_reg)
    begin
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
      ack_seen_reg <= 1'b0;
      resp_valid_o <= 1'b0;
      rd_byte_o    <= 8'h00;
      lnk_dc_reg   <= fspr_pkg::RST_DC;
    end
    else
    begin
      ack_s1_reg   <= ack_tgl_reg;
      ack_s2_reg   <= ack_s1_reg;
      ack_seen_reg <= ack_s2_reg;
      resp_valid_o <= ack_evt;
      if (ack_evt)
      begin
        rd_byte_o  <= resp_reg.rd_byte;
        lnk_dc_reg <= resp_reg.dummy_config_bit;
      end
    end
  end

  always_comb
  begin
    dummy_dual_o = lnk_dc_reg ? fspr_pkg::DUMMY_DUAL_DC1 : fspr_pkg::DUMMY_DUAL_DC0; // RL16
    dummy_quad_o = lnk_dc_reg ? fspr_pkg::DUMMY_QUAD_DC1 : fspr_pkg::DUMMY_QUAD_DC0; // RL17
  end

  a_dummy_counts : assert property (@(posedge lnk_clk_i) disable iff (rst_hold_reg || lnk_rst_reg) // RL17
    (dummy_quad_o == (lnk_dc_reg ? 4'hA : 4'h6)) && (dummy_dual_o == (lnk_dc_reg ? 4'h8 : 4'h4)))
    else $error("dummy cycle count does not follow dummy bit");

  ////////////////////////////////////////////////////////////////////////////
  // system domain: synchronisers

  logic req_s1_reg;
  logic req_s2_reg;
  logic req_seen_reg;
  logic wp_s1_reg;
  logic wp_n_reg;
  logic hr_s1_reg;
  logic hold_rst_n_reg;
  logic cmd_evt;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || rst_hold_reg)
    begin
      req_s1_reg     <= 1'b0;
      req_s2_reg     <= 1'b0;
      req_seen_reg   <= 1'b0;
      wp_s1_reg      <= 1'b1;
      wp_n_reg       <= 1'b1;
      hr_s1_reg      <= 1'b1;
      hold_rst_n_reg <= 1'b1;
    end
    else
    begin
      req_s1_reg     <= req_tgl_reg;
      req_s2_reg     <= req_s1_reg;
      req_seen_reg   <= req_s2_reg;
      wp_s1_reg      <= wp_n_i;
      wp_n_reg       <= wp_s1_reg;
      hr_s1_reg      <= hold_rst_n_i;
      hold_rst_n_reg <= hr_s1_reg;
    end
  end

  assign cmd_evt = req_s2_reg ^ req_seen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // command decode and status bits

  logic [4:0] bp_reg;
  logic [1:0] srp_reg;
  logic       qe_reg;
  logic       cmp_reg;
  logic [2:0] lb_reg;
  logic       dc_reg;
  logic [1:0] drv_reg;
  logic       hold_sel_reg;
  logic       wel_reg;
  logic       esus_reg;
  logic       psus_reg;
  logic       rst_arm_reg;
  logic [7:0] sr_busy_cnt_reg;
  logic [7:0] op;
  logic [7:0] wdat;
  logic       is_write_status_command;
  logic       is_prog;
  logic       is_erase;
  logic       is_chip;
  logic       wp_effective;
  logic       sr_write_ok;
  logic       chip_ok;
  logic       sw_reset;
  logic       busy_flag;

  function automatic logic [7:0] status_byte(input logic [7:0] rdop,
                                             input logic [7:0] b1,
                                             input logic [7:0] b2,
                                             input logic [7:0] b3);
    logic [7:0] r;
    r = 8'h00;
    case (rdop)
      fspr_pkg::OP_RDSR1: r = b1;
      fspr_pkg::OP_RDSR2: r = b2;
      fspr_pkg::OP_RDSR3: r = b3;
      default:            r = 8'h00;
    endcase
    return r;
  endfunction

  logic [7:0] status_protect_byte;
  logic [7:0] status_quad_lock_byte;
  logic [7:0] status_config_byte;

  assign busy_flag = array_busy_i || (sr_busy_cnt_reg != 8'h00); // RL21

  always_comb
  begin
    status_protect_byte = 8'h00;
    status_protect_byte[fspr_pkg::B1_SRP_LO]                 = srp_reg[0];
    status_protect_byte[fspr_pkg::B1_BP_LSB +: 5]            = bp_reg;
    status_protect_byte[fspr_pkg::B1_WEL]                    = wel_reg;
    status_protect_byte[fspr_pkg::B1_BUSY]                   = busy_flag;
    status_quad_lock_byte = 8'h00;
    status_quad_lock_byte[fspr_pkg::B2_ESUS]                 = esus_reg;
    status_quad_lock_byte[fspr_pkg::B2_CMP]                  = cmp_reg;
    status_quad_lock_byte[fspr_pkg::B2_LB_LSB +: 3]          = lb_reg;
    status_quad_lock_byte[fspr_pkg::B2_PSUS]                 = psus_reg;
    status_quad_lock_byte[fspr_pkg::B2_QE]                   = qe_reg;
    status_quad_lock_byte[fspr_pkg::B2_SRP_HI]               = srp_reg[1];
    status_config_byte = 8'h00;
    status_config_byte[fspr_pkg::B3_HOLD]                    = hold_sel_reg;
    status_config_byte[fspr_pkg::B3_DRV_LSB +: 2]            = drv_reg;
    status_config_byte[fspr_pkg::B3_DC]                      = dc_reg;
  end

  always_comb
  begin
    op       = cmd_hold_reg.opcode;
    wdat     = cmd_hold_reg.data;
    is_write_status_command  = (op == fspr_pkg::OP_WRSR1) || (op == fspr_pkg::OP_WRSR2)
               || (op == fspr_pkg::OP_WRSR3);
    is_prog  = (op == fspr_pkg::OP_PROG) || (op == fspr_pkg::OP_QPROG);
    is_erase = (op == fspr_pkg::OP_SECT_ER) || (op == fspr_pkg::OP_BLK32_ER)
               || (op == fspr_pkg::OP_BLK64_ER);
    is_chip  = (op == fspr_pkg::OP_CHIP_ER_A) || (op == fspr_pkg::OP_CHIP_ER_B);
    // write-protect pin only acts while quad mode is off
    wp_effective = qe_reg || wp_n_reg; // RL10
    case (srp_reg)
      fspr_pkg::SRP_SOFTWARE: sr_write_ok = wel_reg;                // RL5
      fspr_pkg::SRP_HARDWARE: sr_write_ok = wel_reg && wp_effective; // RL6 RL7 RL3
      fspr_pkg::SRP_LOCKDOWN: sr_write_ok = 1'b0;                   // RL8
      fspr_pkg::SRP_ONE_TIME: sr_write_ok = 1'b0;                   // RL9
      default:                sr_write_ok = 1'b0;
    endcase
    chip_ok = ((bp_reg[2:0] == 3'h0) && !cmp_reg)
              || ((bp_reg[2:0] == 3'h7) && cmp_reg); // RL4
    sw_reset = rst_arm_reg && (op == fspr_pkg::OP_RST);
  end

  // software reset arming: 99 must directly follow 66
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rst_arm_reg <= 1'b0;
    else if (cmd_evt)
      rst_arm_reg <= (op == fspr_pkg::OP_RST_EN);
  end

  // non-volatile status fields; power cycle is rst_i
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      bp_reg       <= fspr_pkg::RST_BP;
      srp_reg      <= fspr_pkg::RST_SRP; // RL8
      qe_reg       <= fspr_pkg::RST_QE;
      cmp_reg      <= fspr_pkg::RST_CMP;
      lb_reg       <= fspr_pkg::RST_LB; // RL11
      dc_reg       <= fspr_pkg::RST_DC;
      drv_reg      <= fspr_pkg::RST_DRV;
      hold_sel_reg <= fspr_pkg::RST_HOLD_SEL;
    end
    else if (cmd_evt && is_write_status_command && sr_write_ok && !busy_flag) // RL1
    begin
      case (op)
        fspr_pkg::OP_WRSR1:
        begin
          srp_reg[0] <= wdat[fspr_pkg::B1_SRP_LO];
          bp_reg     <= wdat[fspr_pkg::B1_BP_LSB +: 5]; // RL2
        end
        fspr_pkg::OP_WRSR2:
        begin
          cmp_reg    <= wdat[fspr_pkg::B2_CMP]; // RL13
          lb_reg     <= lb_reg | wdat[fspr_pkg::B2_LB_LSB +: 3]; // RL11 RL12
          qe_reg     <= wdat[fspr_pkg::B2_QE];
          srp_reg[1] <= wdat[fspr_pkg::B2_SRP_HI];
        end
        fspr_pkg::OP_WRSR3:
        begin
          hold_sel_reg <= wdat[fspr_pkg::B3_HOLD];
          drv_reg      <= wdat[fspr_pkg::B3_DRV_LSB +: 2]; // RL19
          dc_reg       <= wdat[fspr_pkg::B3_DC];
        end
        default:
        begin
          bp_reg <= bp_reg;
        end
      endcase
    end
  end

  // write enable latch
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      wel_reg <= 1'b0;
    else if (cmd_evt)
    begin
      if (op == fspr_pkg::OP_WREN)
        wel_reg <= 1'b1;
      else if ((op == fspr_pkg::OP_WRDI) || sw_reset)
        wel_reg <= 1'b0;
      else if (is_write_status_command && sr_write_ok && !busy_flag)
        wel_reg <= 1'b0;
      else if ((is_prog || is_erase) && wel_reg && !region_hit_i && !busy_flag)
        wel_reg <= 1'b0;
      else if (is_chip && wel_reg && chip_ok && !busy_flag)
        wel_reg <= 1'b0;
    end
  end

  // status write busy time
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sr_busy_cnt_reg <= 8'h00;
    else if (cmd_evt && is_write_status_command && sr_write_ok && !busy_flag)
      sr_busy_cnt_reg <= fspr_pkg::SR_WRITE_CYC; // RL21
    else if (sr_busy_cnt_reg != 8'h00)
      sr_busy_cnt_reg <= sr_busy_cnt_reg - 8'h01;
  end

  // suspend flags
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      esus_reg <= 1'b0;
      psus_reg <= 1'b0;
    end
    else if (cmd_evt)
    begin
      if ((op == fspr_pkg::OP_RESUME) || sw_reset)
      begin
        esus_reg <= 1'b0; // RL15
        psus_reg <= 1'b0; // RL15
      end
      else if ((op == fspr_pkg::OP_SUSPEND) && array_busy_i)
      begin
        esus_reg <= esus_reg || array_is_erase_i;  // RL14
        psus_reg <= psus_reg || !array_is_erase_i; // RL14
      end
    end
  end

  // operation grants to the array engine
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prog_start_o       <= 1'b0;
      erase_start_o      <= 1'b0;
      chip_erase_start_o <= 1'b0;
      cmd_reject_o       <= 1'b0;
      erase_suspend_o    <= 1'b0;
      program_suspend_o  <= 1'b0;
      resume_o           <= 1'b0;
    end
    else
    begin
      prog_start_o       <= cmd_evt && is_prog && wel_reg && !region_hit_i
                            && !busy_flag; // RL1 RL2
      erase_start_o      <= cmd_evt && is_erase && wel_reg && !region_hit_i
                            && !busy_flag; // RL1 RL2
      chip_erase_start_o <= cmd_evt && is_chip && wel_reg && chip_ok && !busy_flag; // RL4
      cmd_reject_o       <= cmd_evt && (((is_prog || is_erase)
                            && (!wel_reg || region_hit_i || busy_flag))
                            || (is_chip && (!wel_reg || !chip_ok || busy_flag))
                            || (is_write_status_command && (!sr_write_ok || busy_flag))); // RL1
      erase_suspend_o    <= cmd_evt && (op == fspr_pkg::OP_SUSPEND) && array_busy_i
                            && array_is_erase_i;
      program_suspend_o  <= cmd_evt && (op == fspr_pkg::OP_SUSPEND) && array_busy_i
                            && !array_is_erase_i;
      resume_o           <= cmd_evt && (op == fspr_pkg::OP_RESUME);
    end
  end

  // answer back to the link domain
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || rst_hold_reg)
    begin
      ack_tgl_reg <= 1'b0;
      resp_reg    <= '0;
    end
    else if (cmd_evt)
    begin
      ack_tgl_reg               <= !ack_tgl_reg;
      resp_reg.rd_byte          <= status_byte(op, status_protect_byte,
                                               status_quad_lock_byte, status_config_byte);
      resp_reg.dummy_config_bit <= dc_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin functions and status outputs

  always_comb
  begin
    block_protect_o      = bp_reg;
    protect_complement_o = cmp_reg; // RL13
    security_lock_o      = lb_reg;
    drive_strength_o     = drv_reg; // RL19
    quad_enable_o        = qe_reg;  // RL10
    busy_flag_o          = busy_flag;
    hold_o      = !qe_reg && hold_sel_reg && !hold_rst_n_reg;  // RL22 RL23
    pin_reset_o = !qe_reg && !hold_sel_reg && !hold_rst_n_reg; // RL20 RL22
  end

  a_wel_gate : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL1
    cmd_evt && !wel_reg |=> !prog_start_o && !erase_start_o && !chip_erase_start_o)
    else $error("operation granted with write enable latch clear");

  a_hw_protect : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL6
    cmd_evt && is_write_status_command && (srp_reg == 2'h1) && !wp_n_reg && !qe_reg
    |=> $stable(bp_reg) && $stable(srp_reg) && cmd_reject_o)
    else $error("status write taken while hardware protected");

  a_lockdown_hold : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL8
    srp_reg[1] |=> srp_reg[1] && $stable(bp_reg) && $stable(qe_reg))
    else $error("status changed under lock-down");

  a_sw_accept : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL5
    cmd_evt && (op == 8'h01) && (srp_reg == 2'h0) && wel_reg && !busy_flag
    |=> (bp_reg == $past(wdat[6:2])) && !wel_reg && busy_flag_o)
    else $error("software protected status write not applied");

  a_lock_sticky : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL12
    (lb_reg & $past(lb_reg)) == $past(lb_reg))
    else $error("security lock bit cleared");

  a_chip_erase : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL4
    chip_erase_start_o |-> $past(cmp_reg) ? ($past(bp_reg[2:0]) == 3'h7)
                                          : ($past(bp_reg[2:0]) == 3'h0))
    else $error("chip erase granted with protected bits");

  a_suspend_clear : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL15
    cmd_evt && (op == 8'h7A) |=> !esus_reg && !psus_reg ##1 !resume_o)
    else $error("suspend flags not cleared by resume");

  a_sr_busy : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL21
    $rose(sr_busy_cnt_reg != 8'h00) |-> busy_flag_o [*8])
    else $error("busy flag dropped during status write");

  a_quad_pins : assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL22
    qe_reg |-> !hold_o && !pin_reset_o)
    else $error("hold or reset active in quad mode");

endmodule

`default_nettype wire

/* File: bench/fspr_host.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module fspr_host (
  input  wire logic           lnk_clk_i,
  input  wire logic           ready_i,
  input  wire logic           resp_valid_i,
  input  wire logic [7:0]     rd_byte_i,
  output logic                cmd_valid_o,
  output fspr_pkg::fspr_cmd_t cmd_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_o = 16'h0000;
  end
  // one outstanding command; released lines carry the inverse value
  task automatic xfer(input logic [7:0] op, input logic [7:0] dat,
                      output logic [7:0] rd);
    int n;
    rd = 8'hXX;
    @(negedge lnk_clk_i);
    for (n = 0; n < 40 && ready_i !== 1'b1; n++) @(negedge lnk_clk_i);
    cmd_o <= {op, dat};
    cmd_valid_o <= 1'b1;
    @(negedge lnk_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= ~{op, dat};
    for (n = 0; n < 40 && resp_valid_i !== 1'b1; n++) @(negedge lnk_clk_i);
    if (resp_valid_i === 1'b1) rd = rd_byte_i;
  endtask
endmodule
`default_nettype wire

/* File: bench/flash_status_protection_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_status_protection_regs_tb;
  logic clk_sys_i, rst_i, lnk_clk_i, cmd_valid_i, wp_n_i, hold_rst_n_i, region_hit_i;
  logic array_busy_i, array_is_erase_i, cmd_ready_o, resp_valid_o, busy_flag_o;
  logic prog_start_o, erase_start_o, chip_erase_start_o, cmd_reject_o, erase_suspend_o;
  logic program_suspend_o, resume_o, protect_complement_o, quad_enable_o, hold_o, pin_reset_o;
  logic [7:0] rd_byte_o, rd;
  logic [3:0] dummy_dual_o, dummy_quad_o;
  logic [4:0] block_protect_o;
  logic [2:0] security_lock_o;
  logic [1:0] drive_strength_o;
  fspr_pkg::fspr_cmd_t cmd_i;
  int error_cnt = 0, n_compared = 0, rej_n = 0, prog_n = 0, er_n = 0, ce_n = 0;
  int es_n = 0, ps_n = 0, rs_n = 0;
  fspr_regs fspr_regs_i (.*);
  fspr_host fspr_host_i (.lnk_clk_i(lnk_clk_i), .ready_i(cmd_ready_o),
    .resp_valid_i(resp_valid_o), .rd_byte_i(rd_byte_o), .cmd_valid_o(cmd_valid_i),
    .cmd_o(cmd_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    lnk_clk_i = 1'b0;
    #7;
    forever #24 lnk_clk_i = ~lnk_clk_i;
  end
  always @(negedge clk_sys_i)
  begin
    if (cmd_reject_o === 1'b1) rej_n++;
    if (prog_start_o === 1'b1) prog_n++;
    if (erase_start_o === 1'b1) er_n++;
    if (chip_erase_start_o === 1'b1) ce_n++;
    if (erase_suspend_o === 1'b1) es_n++;
    if (program_suspend_o === 1'b1) ps_n++;
    if (resume_o === 1'b1) rs_n++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic c(input logic [7:0] op, input logic [7:0] d);
    fspr_host_i.xfer(op, d, rd);
    @(negedge clk_sys_i);
  endtask
  // write enable, command, then wait out the status write busy time
  task automatic w(input logic [7:0] op, input logic [7:0] d);
    c(8'h06, 8'h00);
    c(op, d);
    for (int i = 0; i < 40 && busy_flag_o !== 1'b0; i++) @(negedge clk_sys_i);
  endtask
  task automatic reset;
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (16) @(negedge clk_sys_i);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    c(8'h05, 8'h00); chk("sr1", 8'h00, rd);
    c(8'h35, 8'h00); chk("sr2", 8'h00, rd);
    c(8'h15, 8'h00); chk("sr3", 8'hA0, rd);
    chk("dual", 8'h04, {4'h0, dummy_dual_o});
    chk("quad", 8'h06, {4'h0, dummy_quad_o});
  endtask
  task automatic t_wel;
    c(8'h01, 8'h1C); c(8'h05, 8'h00); chk("no wel", 8'h00, rd);
    c(8'h06, 8'h00); c(8'h05, 8'h00); chk("wel", 8'h02, rd);
    c(8'h04, 8'h00); c(8'h05, 8'h00); chk("wrdi", 8'h00, rd);
    w(8'h01, 8'h1C); c(8'h05, 8'h00); chk("sr1 wr", 8'h1C, rd);
    chk("bp", 8'h07, {3'h0, block_protect_o});
  endtask
  task automatic t_erase;
    int ce, p, e, r;
    ce = ce_n; p = prog_n; e = er_n;
    w(8'hC7, 8'h00); chk("ce cmp0", 8'h00, 8'(ce_n - ce));
    w(8'h31, 8'h40); w(8'h60, 8'h00); chk("ce cmp1", 8'h01, 8'(ce_n - ce));
    chk("cmp", 8'h01, {7'h0, protect_complement_o});
    region_hit_i = 1'b1;
    w(8'h02, 8'h00); chk("pp hit", 8'h00, 8'(prog_n - p));
    region_hit_i = 1'b0;
    w(8'h32, 8'h00); w(8'h20, 8'h00); w(8'h52, 8'h00); r = rej_n; c(8'hD8, 8'h00);
    chk("pp", 8'h01, 8'(prog_n - p));
    chk("se", 8'h02, 8'(er_n - e));
    chk("be no wel", 8'h01, 8'(rej_n - r));
  endtask
  task automatic t_srp;
    w(8'h01, 8'h9C); wp_n_i = 1'b0;
    w(8'h01, 8'h80); c(8'h05, 8'h00); chk("hw lock", 8'h9C, rd & 8'hFC);
    wp_n_i = 1'b1;
    w(8'h01, 8'h80); c(8'h05, 8'h00); chk("hw open", 8'h80, rd);
  endtask
  task automatic t_lockdown;
    w(8'h01, 8'h00); w(8'h31, 8'h01);
    w(8'h01, 8'h1C); c(8'h05, 8'h00); chk("lockdown", 8'h00, rd & 8'hFC);
    reset; c(8'h35, 8'h00); chk("pwr cycle", 8'h00, rd);
    w(8'h01, 8'h80); w(8'h31, 8'h01);
    w(8'h01, 8'h1C); c(8'h05, 8'h00); chk("one time", 8'h80, rd & 8'hFC);
    reset;
  endtask
  task automatic t_lock_bits;
    w(8'h31, 8'h08); chk("lb1", 8'h01, {5'h0, security_lock_o});
    w(8'h31, 8'h10); chk("lb2", 8'h03, {5'h0, security_lock_o});
    w(8'h31, 8'h00); chk("lb keep", 8'h03, {5'h0, security_lock_o});
    reset; chk("lb rst", 8'h00, {5'h0, security_lock_o});
  endtask
  task automatic t_suspend;
    array_busy_i = 1'b1; array_is_erase_i = 1'b1;
    c(8'h05, 8'h00); chk("busy", 8'h01, rd & 8'h01);
    c(8'h75, 8'h00); c(8'h35, 8'h00); chk("esus", 8'h80, rd);
    c(8'h7A, 8'h00); c(8'h35, 8'h00); chk("resume", 8'h00, rd);
    array_is_erase_i = 1'b0;
    c(8'h75, 8'h00); c(8'h35, 8'h00); chk("psus", 8'h04, rd);
    c(8'h66, 8'h00); c(8'h99, 8'h00); c(8'h35, 8'h00); chk("swrst", 8'h00, rd);
    c(8'h75, 8'h00); array_busy_i = 1'b0; reset;
    c(8'h35, 8'h00); chk("sus pwr", 8'h00, rd);
    chk("es pulse", 8'h01, 8'(es_n)); chk("ps pulse", 8'h02, 8'(ps_n));
    chk("resume pulse", 8'h01, 8'(rs_n));
  endtask
  task automatic t_config;
    logic [1:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = 2'(i);
      w(8'h11, {1'b1, d, 4'h0, d[0]}); c(8'h15, 8'h00);
      chk("sr3 cfg", {1'b1, d, 4'h0, d[0]}, rd);
      chk("drv", {6'h0, d}, {6'h0, drive_strength_o});
      chk("dual", d[0] ? 8'h08 : 8'h04, {4'h0, dummy_dual_o});
      chk("quad", d[0] ? 8'h0A : 8'h06, {4'h0, dummy_quad_o});
    end
  endtask
  task automatic t_pins;
    hold_rst_n_i = 1'b0; repeat (4) @(negedge clk_sys_i);
    chk("hold", 8'h01, {6'h0, pin_reset_o, hold_o});
    hold_rst_n_i = 1'b1; w(8'h11, 8'h20); hold_rst_n_i = 1'b0; repeat (4) @(negedge clk_sys_i);
    chk("pin rst", 8'h02, {6'h0, pin_reset_o, hold_o});
    hold_rst_n_i = 1'b1; w(8'h31, 8'h02); hold_rst_n_i = 1'b0; repeat (4) @(negedge clk_sys_i);
    chk("quad pins", 8'h01, {5'h0, pin_reset_o, hold_o, quad_enable_o});
    hold_rst_n_i = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {wp_n_i, hold_rst_n_i} = 2'h3;
    {array_busy_i, array_is_erase_i, region_hit_i} = 3'h0;
    reset;
    t_defaults; t_wel; t_erase; t_srp; t_lockdown;
    t_lock_bits; t_suspend; t_config; t_pins;
    close_out;
  end
  initial
  begin
    #200000;
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
